//--- rtl/lin_frame_defines.svh
`ifndef LIN_FRAME_DEFINES_SVH
`define LIN_FRAME_DEFINES_SVH
`define PCLK_PERIOD_NS 25
`define LIN_BIT_NS 52083
`define LIN_BIT_CYC (`LIN_BIT_NS / `PCLK_PERIOD_NS)
`define LIN_HALF_CYC (`LIN_BIT_CYC / 2)
`define LIN_BRK_BITS 11
`define LIN_BRK_CYC (`LIN_BRK_BITS * `LIN_BIT_CYC)
`define LIN_FRAME_MAX_NS 9792000
`define LIN_FRAME_MAX_CYC (`LIN_FRAME_MAX_NS / `PCLK_PERIOD_NS)
`define BIT_START 4'h0
`define BIT_STOP 4'h9
`define FLD_SYNC 4'h0
`define FLD_PID 4'h1
`define FLD_DATA0 4'h2
`define NDAT_2 4'h2
`define NDAT_4 4'h4
`define NDAT_8 4'h8
`define SYNC_BYTE 8'h55
`define ID_CMD_FRAME 6'h3C
`define ID_IND_READ 6'h3D
`define CMD_MARKER 8'h80
`define CMD_FULL_STATUS 7'h01
`define REG_ERR 8'h00
`define REG_CFG 8'h04
`define REG_IDMAP 8'h08
`define REG_STAT 8'h0C
`define REG_RXD_LO 8'h10
`define REG_RXD_HI 8'h14
`define REG_TXD_LO 8'h18
`define REG_TXD_HI 8'h1C
`define ERR_BIT 0
`define ERR_HDR 1
`define ERR_DATA 2
`define ERR_TMO 3
`define CFG_ADM 4
`define CFG_RST 5'h00
`define MAP_GP_LSB 0
`define MAP_BND_LSB 8
`define MAP_RD_LSB 16
`define MAP_CMD_LSB 24
`define IDMAP_RST 32'h003F3F3F
`define ST_CMD_LSB 8
`define ST_PEND 15
`define ST_PREP 16
`define ST_ID_LSB 24
`endif

//--- rtl/lin_pkg.sv
package lin_pkg;
	typedef logic [31:0] word_t;
	typedef logic [7:0] byte_t;
	typedef enum logic [2:0] {st_idle, st_brk, st_brk_end, st_wait, st_rx, st_tx} lin_state_t;
endpackage : lin_pkg

//--- rtl/lin_slave_frame_handler.sv
// Function
// - checksum mismatch or missing stop bit raise the data error flag
// - identifier parity failure or bad sync field raise the header error flag
// - a frame exceeding the maximum duration after its first data byte raises the timeout flag
// - while sending, each driven bit is compared with the bus; mismatch flags bit error
// - flags hold until a full-status read command frame clears the whole register
// - node address is 7 bits from 4 stored bits and 3 strap pins
// - a stored mode bit chooses how stored and strap bits are arranged
// - frame is identifier, then 2, 4 or 8 data bytes, then checksum
// - checksum is inverted end-around-carry sum of data bytes only
// - id bit 6 is xor of bits 0,1,2,4; bit 7 inverted xor of 1,3,4,5
// - id bits 5:4 give length: 00/01 two, 10 four, 11 eight bytes
// - command frames need first data byte equal to the 0x80 marker; other values make the node ignore the frame
// - general writing frame of 2 or 4 bytes carries command in first byte
// - broadcast bit zero makes all act, else only the addressed node acts
// - identifier bound to a command executes without address check
// - two-byte frame with identifier bound to node and command is accepted
// - eight-byte command frame carries marker, command, node address and parameters
// - master sends sync and identifier; one slave sends data and checksum
// - direct read identifier answers with no preparing frame, no other action
// - indirect read is answered only right after a preparing frame for this node
// - every response carries the node address
// - identifier 0x3D is an eight-byte indirect read needing a preparing frame
// - error register: timeout bit 3, data 2, header 1, bit error 0
`include "lin_frame_defines.svh"
module lin_slave_frame_handler #(
	parameter int FRAME_TIMEOUT_CYC = `LIN_FRAME_MAX_CYC,
	parameter int BIT_CYC = `LIN_BIT_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire lin_pkg::word_t pwdata,
	output logic pready,
	output lin_pkg::word_t prdata,
	output logic pslverr,
	input wire logic lin_rx_i,
	output logic lin_tx_o,
	output logic lin_tx_oe,
	input wire logic [2:0] strap_address_pins
);
	import lin_pkg::*;

	logic rx_meta_r, rx_r;
	logic [2:0] strap_meta_r, strap_r;
	logic [3:0] err_r, err_set;
	logic [4:0] cfg_r;
	word_t map_r, txd_lo_r, txd_hi_r, prdata_r;
	logic pslverr_r, oe_r;
	logic [6:0] last_cmd_r;
	logic [5:0] last_id_r, id_r;
	logic pend_r, prep_r;
	lin_state_t st_r;
	logic [11:0] tick_r;
	logic [3:0] bit_r, fld_r, ndat_r;
	logic [15:0] brk_r;
	logic [19:0] tmr_r;
	byte_t shf_r, sum_r, tx_byte_r, tx_src;
	byte_t rxbuf_r [0:7];
	logic [6:0] node_addr, cmd_sel;
	logic [5:0] gp_id, bnd_id, rd_id;
	logic [55:0] resp_vec;
	logic [3:0] nf;
	logic mid, bit_end, byte_done, cks_fld, pid_ok, resp_new, cks_ok, hdr_bad;
	logic tmo, hit, addressed, act, full_clr, drv_lvl, ld_tx, tx_done, setup, wr;

	function automatic logic par_ok(input byte_t p);
		return (p[6] == (p[0] ^ p[1] ^ p[2] ^ p[4])) && (p[7] == !(p[1] ^ p[3] ^ p[4] ^ p[5]));
	endfunction : par_ok

	function automatic logic [3:0] len_of(input logic [1:0] b);
		return b == 2'b11 ? `NDAT_8 : (b == 2'b10 ? `NDAT_4 : `NDAT_2);
	endfunction : len_of

	function automatic byte_t eac(input byte_t s, input byte_t b);
		logic [8:0] w;
		w = {1'b0, s} + {1'b0, b};
		return w[7:0] + {7'h00, w[8]};
	endfunction : eac

	// bus pin and straps come from outside the clock domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_meta_r <= 1'b1;
			rx_r <= 1'b1;
			strap_meta_r <= 3'h0;
			strap_r <= 3'h0;
		end else begin
			rx_meta_r <= lin_rx_i;
			rx_r <= rx_meta_r;
			strap_meta_r <= strap_address_pins;
			strap_r <= strap_meta_r;
		end
	end

	assign node_addr = cfg_r[`CFG_ADM] ? {strap_r, cfg_r[3:0]} : {cfg_r[3:0], strap_r};
	assign gp_id = map_r[`MAP_GP_LSB +: 6];
	assign bnd_id = map_r[`MAP_BND_LSB +: 6];
	assign rd_id = map_r[`MAP_RD_LSB +: 6];

	// bit time fixed per build, no baud measurement from the sync field
	assign mid = tick_r == 12'(BIT_CYC / 2);
	assign bit_end = tick_r == 12'(BIT_CYC - 1);
	assign byte_done = st_r == st_rx && mid && bit_r == `BIT_STOP;
	assign cks_fld = fld_r == ndat_r + `FLD_DATA0;
	assign tmo = tmr_r >= 20'(FRAME_TIMEOUT_CYC);
	assign pid_ok = byte_done && fld_r == `FLD_PID && rx_r && par_ok(shf_r);
	assign hdr_bad = (fld_r == `FLD_SYNC && shf_r != `SYNC_BYTE) || (fld_r == `FLD_PID && !par_ok(shf_r));
	// direct id always answers; 0x3D only right after a preparing frame
	assign resp_new = shf_r[5:0] == rd_id || (shf_r[5:0] == `ID_IND_READ && prep_r);
	assign cks_ok = byte_done && cks_fld && rx_r && shf_r == ~sum_r;
	assign tx_done = st_r == st_tx && bit_end && bit_r == `BIT_STOP;
	assign drv_lvl = bit_r == `BIT_START ? 1'b0 : (bit_r == `BIT_STOP ? 1'b1 : tx_byte_r[3'(bit_r - 4'h1)]);

	always_comb begin
		cmd_sel = map_r[`MAP_CMD_LSB +: 7];
		hit = 1'b0;
		addressed = 1'b0;
		if (id_r == `ID_CMD_FRAME) begin
			cmd_sel = rxbuf_r[1][6:0];
			hit = rxbuf_r[0] == `CMD_MARKER && ndat_r == `NDAT_8 && rxbuf_r[2][6:0] == node_addr;
			addressed = hit;
		end else if (id_r == gp_id && ndat_r != `NDAT_8) begin
			cmd_sel = rxbuf_r[0][6:0];
			hit = !rxbuf_r[1][7] || rxbuf_r[1][6:0] == node_addr;
			addressed = rxbuf_r[1][7] && hit;
		end else if (id_r == bnd_id) begin
			hit = 1'b1;
		end
	end

	assign act = cks_ok && hit;
	assign full_clr = act && cmd_sel == `CMD_FULL_STATUS;

	always_comb begin
		err_set = 4'h0;
		err_set[`ERR_HDR] = byte_done && rx_r && hdr_bad;
		err_set[`ERR_DATA] = byte_done && (!rx_r || (cks_fld && shf_r != ~sum_r));
		err_set[`ERR_TMO] = tmo && fld_r > `FLD_DATA0;
		err_set[`ERR_BIT] = st_r == st_tx && mid && rx_r != drv_lvl;
	end

	// a new event in the clearing cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_r <= 4'h0;
		end else begin
			err_r <= (full_clr ? 4'h0 : err_r) | err_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_r <= 20'h00000;
		end else if (st_r == st_idle || st_r == st_brk || st_r == st_brk_end) begin
			tmr_r <= 20'h00000;
		end else begin
			tmr_r <= tmr_r + 20'h00001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= st_idle;
			tick_r <= 12'h000;
			bit_r <= `BIT_START;
			brk_r <= 16'h0000;
			fld_r <= `FLD_SYNC;
		end else begin
			unique case (st_r)
				st_idle: begin
					brk_r <= 16'h0000;
					if (!rx_r) begin
						st_r <= st_brk;
					end
				end
				st_brk: begin
					if (rx_r) begin
						st_r <= st_idle;
					end else if (brk_r == 16'(`LIN_BRK_BITS * BIT_CYC - 1)) begin
						st_r <= st_brk_end;
					end else begin
						brk_r <= brk_r + 16'h0001;
					end
				end
				st_brk_end: begin
					fld_r <= `FLD_SYNC;
					if (rx_r) begin
						st_r <= st_wait;
					end
				end
				st_wait: begin
					tick_r <= 12'h000;
					bit_r <= `BIT_START;
					if (tmo) begin
						st_r <= st_idle;
					end else if (!rx_r) begin
						st_r <= st_rx;
					end
				end
				st_rx: begin
					if (tmo) begin
						st_r <= st_idle;
					end else if (mid && bit_r == `BIT_START && rx_r) begin
						st_r <= st_wait;
					end else if (byte_done) begin
						tick_r <= 12'h000;
						bit_r <= `BIT_START;
						fld_r <= fld_r + 4'h1;
						// a zero byte without stop bit is a new break cutting the frame short
						if (!rx_r) begin
							st_r <= shf_r == 8'h00 ? st_brk_end : st_idle;
						end else if (hdr_bad || cks_fld) begin
							st_r <= st_idle;
						end else if (pid_ok && resp_new) begin
							st_r <= st_tx;
						end else begin
							st_r <= st_wait;
						end
					end else if (bit_end) begin
						tick_r <= 12'h000;
						bit_r <= bit_r + 4'h1;
					end else begin
						tick_r <= tick_r + 12'h001;
					end
				end
				st_tx: begin
					// stop driving at once on a collision
					if (tmo || err_set[`ERR_BIT]) begin
						st_r <= st_idle;
					end else if (tx_done) begin
						tick_r <= 12'h000;
						bit_r <= `BIT_START;
						fld_r <= fld_r + 4'h1;
						if (cks_fld) begin
							st_r <= st_idle;
						end
					end else if (bit_end) begin
						tick_r <= 12'h000;
						bit_r <= bit_r + 4'h1;
					end else begin
						tick_r <= tick_r + 12'h001;
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			shf_r <= 8'h00;
		end else if (st_r == st_rx && mid && bit_r != `BIT_START && bit_r != `BIT_STOP) begin
			shf_r <= {rx_r, shf_r[7:1]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum_r <= 8'h00;
		end else if (pid_ok) begin
			sum_r <= 8'h00;
		end else if (byte_done && fld_r >= `FLD_DATA0 && !cks_fld) begin
			sum_r <= eac(sum_r, shf_r);
		end else if (tx_done && !cks_fld) begin
			sum_r <= eac(sum_r, tx_byte_r);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			id_r <= 6'h00;
			ndat_r <= `NDAT_2;
		end else if (pid_ok) begin
			id_r <= shf_r[5:0];
			ndat_r <= shf_r[5:0] == `ID_IND_READ ? `NDAT_8 : len_of(shf_r[5:4]);
		end
	end

	generate
		for (genvar i = 0; i < 8; i++) begin : g_rxbuf
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					rxbuf_r[i] <= 8'h00;
				end else if (byte_done && rx_r && !cks_fld && fld_r == 4'(i) + `FLD_DATA0) begin
					rxbuf_r[i] <= shf_r;
				end
			end
		end
	endgenerate

	assign nf = fld_r + 4'h1;
	assign ld_tx = (pid_ok && resp_new) || tx_done;
	assign resp_vec = {txd_hi_r[23:0], txd_lo_r};

	always_comb begin
		if (st_r == st_tx && nf == ndat_r + `FLD_DATA0) begin
			tx_src = ~eac(sum_r, tx_byte_r);
		end else if (nf == `FLD_DATA0) begin
			tx_src = {1'b1, node_addr};
		end else begin
			tx_src = resp_vec[3'(nf - 4'h3) * 8 +: 8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_byte_r <= 8'h00;
		end else if (ld_tx) begin
			tx_byte_r <= tx_src;
		end
	end

	// open-drain: only the dominant level is driven
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= st_r == st_tx && !drv_lvl;
		end
	end

	assign lin_tx_oe = oe_r;
	assign lin_tx_o = 1'b0;

	// preparing frame arms exactly the next header
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prep_r <= 1'b0;
			pend_r <= 1'b0;
			last_cmd_r <= 7'h00;
			last_id_r <= 6'h00;
		end else begin
			if (act && addressed) begin
				prep_r <= 1'b1;
			end else if (pid_ok) begin
				prep_r <= 1'b0;
			end
			if (act) begin
				pend_r <= 1'b1;
				last_cmd_r <= cmd_sel;
			end else if (wr && paddr == `REG_STAT && pwdata[`ST_PEND]) begin
				pend_r <= 1'b0;
			end
			if (pid_ok) begin
				last_id_r <= shf_r[5:0];
			end
		end
	end

	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_r <= `CFG_RST;
			map_r <= `IDMAP_RST;
			txd_lo_r <= 32'h00000000;
			txd_hi_r <= 32'h00000000;
		end else if (wr) begin
			if (paddr == `REG_CFG) begin
				cfg_r <= pwdata[4:0];
			end
			if (paddr == `REG_IDMAP) begin
				map_r <= pwdata;
			end
			if (paddr == `REG_TXD_LO) begin
				txd_lo_r <= pwdata;
			end
			if (paddr == `REG_TXD_HI) begin
				txd_hi_r <= pwdata;
			end
		end
	end

	// read data captured in the setup cycle so prdata comes from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (setup) begin
			pslverr_r <= 1'b0;
			unique case (paddr)
				`REG_ERR: prdata_r <= {28'h0000000, err_r};
				`REG_CFG: prdata_r <= {27'h0000000, cfg_r};
				`REG_IDMAP: prdata_r <= map_r;
				`REG_STAT: prdata_r <= {2'h0, last_id_r, 7'h00, prep_r, pend_r, last_cmd_r, 1'b0, node_addr};
				`REG_RXD_LO: prdata_r <= {rxbuf_r[3], rxbuf_r[2], rxbuf_r[1], rxbuf_r[0]};
				`REG_RXD_HI: prdata_r <= {rxbuf_r[7], rxbuf_r[6], rxbuf_r[5], rxbuf_r[4]};
				`REG_TXD_LO: prdata_r <= txd_lo_r;
				`REG_TXD_HI: prdata_r <= txd_hi_r;
				default: begin
					prdata_r <= 32'h00000000;
					pslverr_r <= 1'b1;
				end
			endcase
		end
	end

	assign prdata = prdata_r;
	assign pslverr = pslverr_r;
	assign pready = 1'b1;

	chk_sync_header: assert property (@(posedge pclk) disable iff (!presetn)
		byte_done && fld_r == `FLD_SYNC && rx_r && shf_r != `SYNC_BYTE |=> err_r[`ERR_HDR] && st_r == st_idle)
		else $error("bad sync field not flagged");
	chk_parity_header: assert property (@(posedge pclk) disable iff (!presetn)
		byte_done && fld_r == `FLD_PID && rx_r && !par_ok(shf_r) |=> err_r[`ERR_HDR])
		else $error("parity failure not flagged");
	chk_stop_data: assert property (@(posedge pclk) disable iff (!presetn)
		byte_done && !rx_r |=> err_r[`ERR_DATA] && st_r != st_wait)
		else $error("missing stop bit not flagged");
	chk_cks_data: assert property (@(posedge pclk) disable iff (!presetn)
		byte_done && cks_fld && rx_r && shf_r != ~sum_r
		|=> err_r[`ERR_DATA] && $stable(last_cmd_r) && !$rose(pend_r))
		else $error("checksum mismatch not flagged");
	chk_timeout_flag: assert property (@(posedge pclk) disable iff (!presetn)
		st_r != st_idle && fld_r > `FLD_DATA0 && tmr_r == 20'(FRAME_TIMEOUT_CYC)
		|=> err_r[`ERR_TMO] && st_r == st_idle)
		else $error("frame timeout not flagged");
	chk_bit_error: assert property (@(posedge pclk) disable iff (!presetn)
		st_r == st_tx && mid && rx_r != drv_lvl |=> err_r[`ERR_BIT] ##1 !lin_tx_oe)
		else $error("readback mismatch not flagged");
	chk_flags_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!full_clr |=> (err_r & $past(err_r)) == $past(err_r))
		else $error("error flag lost without clear");
	chk_status_clear: assert property (@(posedge pclk) disable iff (!presetn)
		full_clr && err_set == 4'h0 |=> err_r == 4'h0)
		else $error("full status frame did not clear");
	chk_node_addr: assert property (@(posedge pclk) disable iff (!presetn)
		setup && paddr == `REG_STAT |=> prdata[6:0] == (cfg_r[`CFG_ADM] ?
		{strap_r, cfg_r[3:0]} : {cfg_r[3:0], strap_r}))
		else $error("node address wrongly formed");
	chk_frame_length: assert property (@(posedge pclk) disable iff (!presetn)
		pid_ok && shf_r[5:0] != `ID_IND_READ
		|=> ndat_r == (id_r[5] ? (id_r[4] ? `NDAT_8 : `NDAT_4) : `NDAT_2))
		else $error("data length not taken from identifier");
	chk_indirect_gate: assert property (@(posedge pclk) disable iff (!presetn)
		pid_ok && shf_r[5:0] == `ID_IND_READ && !prep_r && shf_r[5:0] != rd_id |=> st_r != st_tx)
		else $error("unprepared indirect read answered");
	chk_resp_addr: assert property (@(posedge pclk) disable iff (!presetn)
		pid_ok && resp_new && !tmo |=> st_r == st_tx && tx_byte_r == {1'b1, node_addr})
		else $error("response lacks node address");
	cov_read_resp: cover property (@(posedge pclk) disable iff (!presetn) tx_done && cks_fld);
	cov_full_clear: cover property (@(posedge pclk) disable iff (!presetn) full_clr && err_r != 4'h0);
	cov_indirect: cover property (@(posedge pclk) disable iff (!presetn) pid_ok && resp_new && prep_r);
	cov_timeout: cover property (@(posedge pclk) disable iff (!presetn) err_set[`ERR_TMO]);
endmodule : lin_slave_frame_handler

//--- tb/lin_master_model.sv
`include "lin_frame_defines.svh"
module lin_master_model #(
	parameter int BIT_CYC = `LIN_BIT_CYC
) (
	input wire logic pclk,
	input wire logic bus,
	output logic drive_low,
	output lin_pkg::byte_t rx_byte,
	output logic rx_valid
);
	timeunit 1ns;
	timeprecision 100ps;
	import lin_pkg::*;

	initial begin
		drive_low = 1'b0;
		rx_byte = 8'h00;
		rx_valid = 1'b0;
	end

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : wait_cyc

	task automatic send_bit(input logic b, input int len);
		drive_low <= !b;
		wait_cyc(len);
	endtask : send_bit

	task automatic send_break();
		drive_low <= 1'b1;
		wait_cyc(13 * BIT_CYC);
		drive_low <= 1'b0;
		wait_cyc(BIT_CYC);
	endtask : send_break

	// short stop after the identifier: the node answers with no response space
	task automatic send_byte(input byte_t b, input int stop_len);
		send_bit(1'b0, BIT_CYC);
		for (int i = 0; i < 8; i++) begin
			send_bit(b[i], BIT_CYC);
		end
		send_bit(1'b1, stop_len);
	endtask : send_byte

	task automatic recv_byte(input logic clobber);
		int n;
		byte_t v;
		n = 0;
		while (bus && n < 3 * BIT_CYC) begin
			@(posedge pclk);
			n++;
		end
		if (clobber) begin
			// hold the bus dominant so the node reads back a wrong level
			drive_low <= 1'b1;
			wait_cyc(10 * BIT_CYC);
			drive_low <= 1'b0;
		end else begin
			wait_cyc(BIT_CYC / 2);
			for (int i = 0; i < 8; i++) begin
				wait_cyc(BIT_CYC);
				v[i] = bus;
			end
			wait_cyc(BIT_CYC);
			rx_byte <= v;
			rx_valid <= 1'b1;
			@(posedge pclk);
			rx_valid <= 1'b0;
		end
	endtask : recv_byte
endmodule : lin_master_model

//--- tb/testbench.sv
`include "lin_frame_defines.svh"
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import lin_pkg::*;
	typedef struct {word_t exp; word_t mask; logic err;} apb_exp_t;
	// short bit time keeps the whole run within the cycle budget
	localparam int BIT = 40;
	localparam logic [5:0] GP_ID = 6'h05;
	localparam logic [5:0] BND_ID = 6'h06;
	localparam logic [5:0] RD_ID = 6'h11;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic lin_tx_o, lin_tx_oe, m_low, rx_valid;
	logic [7:0] paddr;
	word_t pwdata, prdata;
	byte_t rx_byte, txd;
	logic [2:0] strap_address_pins;
	logic [3:0] stored;
	logic [6:0] node;
	integer seed;
	int miscompares, n_tests;
	apb_exp_t apb_q[$];
	apb_exp_t cur;
	byte_t lin_q[$];
	wire logic lin_bus;

	// pull-up bus: dominant when either party pulls low
	assign lin_bus = !(m_low || (lin_tx_oe && !lin_tx_o));

	lin_slave_frame_handler #(.FRAME_TIMEOUT_CYC(130 * BIT), .BIT_CYC(BIT)) DUT (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.lin_rx_i(lin_bus), .lin_tx_o(lin_tx_o), .lin_tx_oe(lin_tx_oe),
		.strap_address_pins(strap_address_pins));
	lin_master_model #(.BIT_CYC(BIT)) master (.pclk(pclk), .bus(lin_bus), .drive_low(m_low),
		.rx_byte(rx_byte), .rx_valid(rx_valid));

	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;

	task automatic check_word(input string name, input word_t exp, input word_t got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check_word

	task automatic check_byte(input string name, input byte_t exp, input byte_t got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask : check_byte

	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
			cur = apb_q.pop_front();
			check_word("prdata", cur.exp, prdata & cur.mask);
			check_word("pslverr", {31'h0, cur.err}, {31'h0, pslverr});
		end
		if (rx_valid === 1'b1) begin
			check_byte("response", lin_q.pop_front(), rx_byte);
		end
	end

	task automatic apb(input logic w, input logic [7:0] a, input word_t d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input word_t exp, input word_t mask, input logic err);
		apb_q.push_back('{exp, mask, err});
		apb(1'b0, a, 32'h0);
	endtask : rd

	function automatic byte_t pid(input logic [5:0] i);
		return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
	endfunction : pid

	function automatic byte_t csum(input byte_t a, input byte_t b);
		logic [8:0] s;
		s = a + b;
		s = s[7:0] + s[8];
		return ~s[7:0];
	endfunction : csum

	function automatic logic [6:0] addr_of(input logic sel);
		return sel ? {strap_address_pins, stored} : {stored, strap_address_pins};
	endfunction : addr_of

	task automatic header(input byte_t id, input int stop_len);
		master.send_break();
		master.send_byte(`SYNC_BYTE, BIT);
		master.send_byte(id, stop_len);
	endtask : header

	task automatic lin_write(input logic [5:0] id, input byte_t d0, input byte_t d1,
		input logic bad_cs);
		header(pid(id), BIT);
		master.send_byte(d0, BIT);
		master.send_byte(d1, BIT);
		master.send_byte(bad_cs ? ~csum(d0, d1) : csum(d0, d1), BIT);
		master.wait_cyc(3 * BIT);
	endtask : lin_write

	// zeros: response bytes after txd that come from cleared transmit words
	task automatic lin_read(input logic [5:0] id, input logic clobber, input int zeros);
		header(pid(id), BIT / 4);
		lin_q.push_back({1'b1, node});
		master.recv_byte(1'b0);
		if (clobber) begin
			master.recv_byte(1'b1);
		end else begin
			lin_q.push_back(txd);
			master.recv_byte(1'b0);
			for (int k = 0; k < zeros; k++) begin
				lin_q.push_back(8'h00);
				master.recv_byte(1'b0);
			end
			lin_q.push_back(csum({1'b1, node}, txd));
			master.recv_byte(1'b0);
		end
		master.wait_cyc(3 * BIT);
	endtask : lin_read

	task automatic finish_test();
		$display("comparisons %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (60000) @(posedge pclk);
		miscompares++;
		finish_test();
	end

	initial begin
		seed = 35;
		miscompares = 0;
		n_tests = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		strap_address_pins = 3'($random(seed));
		stored = 4'($random(seed));
		txd = 8'($random(seed)) | 8'h01;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rd(`REG_ERR, 32'h0, 32'hFFFFFFFF, 1'b0);
		rd(`REG_CFG, 32'h0, 32'hFFFFFFFF, 1'b0);
		rd(`REG_IDMAP, `IDMAP_RST, 32'hFFFFFFFF, 1'b0);
		rd(8'h20, 32'h0, 32'hFFFFFFFF, 1'b1);
		for (int m = 0; m < 2; m++) begin
			// new strap levels settle through the synchroniser during the write
			if (m == 1) begin
				strap_address_pins <= 3'($random(seed));
			end
			apb(1'b1, `REG_CFG, {27'h0, m[0], stored});
			rd(`REG_STAT, {25'h0, addr_of(m[0])}, 32'h7F, 1'b0);
		end
		node = addr_of(1'b1);
		apb(1'b1, `REG_IDMAP, 32'h07110605);
		apb(1'b1, `REG_TXD_LO, {24'h0, txd});
		lin_write(GP_ID, 8'h01, 8'h00, 1'b1);
		rd(`REG_ERR, 32'h4, 32'hFFFFFFFF, 1'b0);
		rd(`REG_STAT, 32'h0, 32'h7F00, 1'b0);
		header(pid(GP_ID) ^ 8'h80, BIT);
		master.wait_cyc(3 * BIT);
		rd(`REG_ERR, 32'h6, 32'hFFFFFFFF, 1'b0);
		header(pid(GP_ID), BIT);
		master.send_byte(8'h02, BIT);
		master.wait_cyc(110 * BIT);
		rd(`REG_ERR, 32'hE, 32'hFFFFFFFF, 1'b0);
		lin_read(RD_ID, 1'b1, 0);
		rd(`REG_ERR, 32'hF, 32'hFFFFFFFF, 1'b0);
		lin_write(GP_ID, 8'h01, 8'h00, 1'b0);
		rd(`REG_ERR, 32'h0, 32'hFFFFFFFF, 1'b0);
		rd(`REG_STAT, 32'h0100, 32'h7F00, 1'b0);
		lin_write(GP_ID, 8'h05, {1'b1, node ^ 7'h01}, 1'b0);
		rd(`REG_STAT, 32'h0100, 32'h7F00, 1'b0);
		lin_write(BND_ID, 8'h33, 8'h44, 1'b0);
		rd(`REG_STAT, 32'h0700, 32'h7F00, 1'b0);
		lin_read(RD_ID, 1'b0, 0);
		lin_write(GP_ID, 8'h02, {1'b1, node}, 1'b0);
		rd(`REG_STAT, 32'h10200, 32'h17F00, 1'b0);
		lin_read(`ID_IND_READ, 1'b0, 6);
		// unprepared indirect read: bus must stay recessive
		header(pid(`ID_IND_READ), BIT / 4);
		lin_q.push_back(8'hFF);
		master.recv_byte(1'b0);
		finish_test();
	end
endmodule : testbench
